/* verilog/dual_channel_spi_register_bank.sv */
`default_nettype none

module dual_channel_spi_register_bank
    import spi_bank_pkg::*;
#(
    parameter logic [15:0] SERIAL_CODE = 16'h5A3C, // Arbitrary value.
    parameter int unsigned ALARM_W = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    output logic sdoOut,
    output logic sdoOe_n,
    input wire logic [2*ALARM_W-1:0] alarmIn,
    output logic alarmOut,
    output logic alarmOe_n,
    output logic calEnable,
    output logic loadDeferred,
    output logic [1:0] activeLoadOn,
    output chan_ctrl_s [1:0] chanCtrl
);

    // ------------------------------------------------------------------
    // Checks and declarations
    // ------------------------------------------------------------------
    // Refuse an alarm width that does not equal the width of one mask word.
    if (ALARM_W != DATA_W) begin : g_bad_alarm_width
        $error("ALARM_W must equal the register width");
    end

    typedef enum {ST_IDLE, ST_SHIFT, ST_DONE} frame_e;

    frame_e state_r, state_nxt;
    logic [4:0] bitCnt_r, bitCnt_nxt;
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic [15:0] shadow_r, shadow_nxt;
    logic readFrame_r, readFrame_nxt;
    logic commit_r, commit_nxt;
    logic sclkD_r, sclkD_nxt;
    logic loadForce_r, loadForce_nxt;
    logic alarmActive_r, alarmActive_nxt;
    logic [15:0] mem_r [2][128];
    logic [15:0] memNxt [2][128];
    logic [2:0] pinsSync;
    logic [2*ALARM_W-1:0] alarmSync;
    logic sclkS, csS, sdiS, sclkRise, sclkFall;
    logic [1:0] chSel;
    logic [6:0] frameAddr;
    logic [15:0] frameData;
    logic [15:0] alarmState [2];

    // ------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------
    // Kind of storage at an address on one channel.
    function automatic reg_kind_e regKind(input logic [6:0] a, input logic c);
        reg_kind_e k;
        k = KIND_RESERVED;
        if (a >= ADDR_LEVEL_FIRST && a <= ADDR_LEVEL_LAST) begin
            k = KIND_LEVEL;
        end else if (a == ADDR_DAC_CTRL || a == ADDR_SPI_CTRL) begin
            k = c ? KIND_RESERVED : KIND_CTRL;
        end else if (a >= ADDR_DRV_CTRL && a <= ADDR_ALARM_MASK) begin
            k = KIND_CTRL;
        end else if (a == ADDR_ALARM_STATE) begin
            k = KIND_READ_ONLY;
        end else if (a == ADDR_SERIAL_CODE) begin
            k = c ? KIND_RESERVED : KIND_READ_ONLY;
        end else if (a >= ADDR_OFS_FIRST && a <= ADDR_OFS_LAST) begin
            k = KIND_OFFSET;
        end else if (a == ADDR_GAIN_LOAD || a == 7'h44 || a == 7'h45) begin
            k = KIND_GAIN;
        end else if (a == 7'h46 || a == 7'h47) begin
            k = c ? KIND_RESERVED : KIND_GAIN;
        end else if (a >= ADDR_GAIN_FI_FIRST && a <= ADDR_GAIN_FI_LAST) begin
            k = KIND_GAIN;
        end else if (a == ADDR_OFS_LOAD || a == 7'h54 || a == 7'h55) begin
            k = KIND_OFFSET;
        end else if (a == 7'h56 || a == 7'h57) begin
            k = c ? KIND_RESERVED : KIND_OFFSET;
        end else if (a == ADDR_OFS_FI || a == 7'h5D || a == 7'h5E) begin
            k = KIND_OFFSET;
        end else if (a >= ADDR_GAIN_MI_FIRST && a <= ADDR_GAIN_MI_LAST) begin
            k = KIND_GAIN;
        end
        return k;
    endfunction

    // Value a location takes at reset.
    function automatic logic [15:0] resetValue(input reg_kind_e k, input logic [6:0] a);
        logic [15:0] v;
        v = RST_CTRL;
        if (k == KIND_GAIN) begin
            v = RST_GAIN;
        end else if (k == KIND_OFFSET) begin
            v = RST_OFFSET;
        end else if (k == KIND_LEVEL) begin
            v = RST_LEVEL;
        end else if (a == ADDR_ALARM_MASK) begin
            v = RST_ALARM_MASK;
        end
        return v;
    endfunction

    // Only storage kinds accept host data.
    function automatic logic writable(input reg_kind_e k);
        return k == KIND_CTRL || k == KIND_LEVEL || k == KIND_GAIN || k == KIND_OFFSET;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pin_sync #(.WIDTH(3)) spiSync (
        .clock(clock),
        .srst(srst),
        .pinIn({sclk, csN, sdi}),
        .pinSync(pinsSync)
    );

    pin_sync #(.WIDTH(2*ALARM_W)) alarmSyncInst (
        .clock(clock),
        .srst(srst),
        .pinIn(alarmIn),
        .pinSync(alarmSync)
    );

    // Edge detection on the synchronised serial clock.
    assign sclkS = pinsSync[2];
    assign csS = pinsSync[1];
    assign sdiS = pinsSync[0];
    assign sclkRise = sclkS & ~sclkD_r;
    assign sclkFall = ~sclkS & sclkD_r;

    // Fields of a completed frame.
    assign chSel = shift_r[POS_CH_HI:POS_CH_LO];
    assign frameAddr = shift_r[POS_ADDR_HI:POS_ADDR_LO];
    assign frameData = shift_r[15:0];

    // ------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------
    // Shifts bits in on rising edges and read data out on falling edges.
    always_comb begin
        logic [6:0] hAddr;
        logic [1:0] hCh;
        logic hChan;
        hAddr = '0;
        hCh = '0;
        hChan = 1'b0;
        state_nxt = state_r;
        bitCnt_nxt = bitCnt_r;
        shift_nxt = shift_r;
        shadow_nxt = shadow_r;
        readFrame_nxt = readFrame_r;
        commit_nxt = 1'b0;
        sclkD_nxt = sclkS;
        if (srst) begin
            state_nxt = ST_IDLE;
            bitCnt_nxt = '0;
            shift_nxt = '0;
            shadow_nxt = '0;
            readFrame_nxt = 1'b0;
            sclkD_nxt = 1'b0;
        end else if (csS) begin
            state_nxt = ST_IDLE;
            bitCnt_nxt = '0;
            readFrame_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (sclkRise) begin
                        shift_nxt = {shift_r[FRAME_BITS-2:0], sdiS};
                        bitCnt_nxt = bitCnt_r + 5'd1;
                        if (bitCnt_nxt == 5'(HDR_BITS)) begin
                            // Header done: fetch the word for a read.
                            readFrame_nxt = shift_nxt[HDR_RW];
                            hCh = shift_nxt[HDR_RW-1:HDR_RW-2];
                            hAddr = shift_nxt[6:0];
                            hChan = ~hCh[0];
                            if (hCh == 2'b00 || regKind(hAddr, hChan) == KIND_RESERVED) begin
                                shadow_nxt = RESERVED_READ;
                            end else if (hAddr == ADDR_SERIAL_CODE) begin
                                shadow_nxt = SERIAL_CODE;
                            end else if (hAddr == ADDR_ALARM_STATE) begin
                                shadow_nxt = alarmState[hChan];
                            end else begin
                                shadow_nxt = mem_r[hChan][hAddr];
                            end
                        end
                        if (bitCnt_nxt == 5'(FRAME_BITS)) begin
                            state_nxt = ST_DONE;
                            commit_nxt = ~shift_nxt[POS_RW];
                        end
                    end else if (sclkFall && readFrame_r && bitCnt_r > 5'(HDR_BITS)) begin
                        shadow_nxt = {shadow_r[14:0], 1'b0};
                    end
                end
                ST_DONE: begin
                    state_nxt = ST_DONE;
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Frame engine registers.
    always_ff @(posedge clock) begin
        state_r <= state_nxt;
        bitCnt_r <= bitCnt_nxt;
        shift_r <= shift_nxt;
        shadow_r <= shadow_nxt;
        readFrame_r <= readFrame_nxt;
        commit_r <= commit_nxt;
        sclkD_r <= sclkD_nxt;
    end

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    // A write lands once per selected channel that has storage there.
    always_comb begin
        memNxt = mem_r;
        if (srst) begin
            for (int c = 0; c < 2; c++) begin
                for (int a = 0; a < 128; a++) begin
                    memNxt[c][a] = resetValue(regKind(7'(a), c[0]), 7'(a));
                end
            end
        end else if (commit_r) begin
            for (int c = 0; c < 2; c++) begin
                // Both bits set means two writes; absent halves drop.
                if (chSel[c] && writable(regKind(frameAddr, c[0]))) begin
                    memNxt[c][frameAddr] = frameData;
                end
            end
        end
    end

    // Storage registers.
    always_ff @(posedge clock) begin
        mem_r <= memNxt;
    end

    // ------------------------------------------------------------------
    // Alarms and forced load
    // ------------------------------------------------------------------
    // Live alarm state with masked sources removed.
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            alarmState[c] = alarmSync[c*ALARM_W +: ALARM_W] & ~mem_r[c][ADDR_ALARM_MASK];
        end
        alarmActive_nxt = srst ? 1'b0 : (|alarmState[0]) | (|alarmState[1]);
        loadForce_nxt = srst | loadForce_r;
    end

    // Alarm and forced-load registers.
    always_ff @(posedge clock) begin
        alarmActive_r <= alarmActive_nxt;
        loadForce_r <= loadForce_nxt;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Serial output is driven while selected or whenever tristating is off.
    assign sdoOut = shadow_r[15];
    assign sdoOe_n = csS & mem_r[0][ADDR_SPI_CTRL][BIT_SPI_TRISTATE];
    assign alarmOut = 1'b0;
    assign alarmOe_n = ~alarmActive_r;
    assign calEnable = mem_r[0][ADDR_DAC_CTRL][BIT_DAC_CAL_EN];
    assign loadDeferred = mem_r[0][ADDR_DAC_CTRL][BIT_DAC_DEFER];

    // Per-channel control decode; an all-zero word turns every chanCtrl field off, but activeLoadOn stays forced on after reset.
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            chanCtrl[c].driverEnable = mem_r[c][ADDR_DRV_CTRL][BIT_DRV_EN];
            chanCtrl[c].driverAltMux = mem_r[c][ADDR_DRV_CTRL][BIT_DRV_ALT_MUX];
            chanCtrl[c].driverLossComp = mem_r[c][ADDR_DRV_CTRL][BIT_DRV_CLC];
            chanCtrl[c].driverRcvTerm = mem_r[c][ADDR_DRV_CTRL][BIT_DRV_RCV_TERM];
            chanCtrl[c].compDiffMode = mem_r[c][ADDR_CMP_CTRL][BIT_CMP_DIFF];
            chanCtrl[c].compLossComp = mem_r[c][ADDR_CMP_CTRL][BIT_CMP_CLC];
            chanCtrl[c].compHysteresis = mem_r[c][ADDR_CMP_CTRL][BIT_CMP_HYST];
            chanCtrl[c].loadEnable = mem_r[c][ADDR_LOAD_CTRL][BIT_LOAD_EN];
            chanCtrl[c].measureEnable = mem_r[c][ADDR_PMU_CTRL][BIT_PMU_EN];
            chanCtrl[c].measureOutEnable = mem_r[c][ADDR_PMU_CTRL][BIT_PMU_OUT_EN];
            chanCtrl[c].measureClamps = mem_r[c][ADDR_PMU_CTRL][BIT_PMU_CLAMP];
            activeLoadOn[c] = loadForce_r | chanCtrl[c].loadEnable;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [15:0] selWord0, selWord1;
    reg_kind_e kind0, kind1;
    assign selWord0 = mem_r[0][frameAddr];
    assign selWord1 = mem_r[1][frameAddr];
    assign kind0 = regKind(frameAddr, 1'b0);
    assign kind1 = regKind(frameAddr, 1'b1);

    reserved_write_a: assert property (@(posedge clock) disable iff (srst)
        commit_r && !writable(kind0) |=> selWord0 == $past(selWord0))
        else $error("Write to a reserved or read-only word changed it");
    ch1_only_a: assert property (@(posedge clock) disable iff (srst)
        commit_r && chSel == 2'b10 && kind1 == KIND_RESERVED |=>
        selWord0 == $past(selWord0) && selWord1 == $past(selWord1))
        else $error("Channel-1 write to a channel-0-only word took effect");
    dual_write_a: assert property (@(posedge clock) disable iff (srst)
        commit_r && chSel == 2'b11 && writable(kind0) && writable(kind1) |=>
        selWord0 == $past(frameData) && selWord1 == $past(frameData))
        else $error("Both-channel write did not load both channels");
    half_drop_a: assert property (@(posedge clock) disable iff (srst)
        commit_r && chSel == 2'b11 && writable(kind0) && !writable(kind1) |=>
        selWord0 == $past(frameData) && selWord1 == $past(selWord1))
        else $error("Channel-1 half of a write was not dropped");
    frame_len_a: assert property (@(posedge clock) disable iff (srst)
        commit_r |-> bitCnt_r == 5'(FRAME_BITS) && $past(sclkRise))
        else $error("Write committed before the frame was complete");
    load_force_a: assert property (@(posedge clock) disable iff (srst)
        $past(srst) ##1 1'b1 |-> activeLoadOn == 2'b11)
        else $error("Active load not forced on after reset");
    sdo_drive_a: assert property (@(posedge clock) disable iff (srst)
        !mem_r[0][ADDR_SPI_CTRL][BIT_SPI_TRISTATE] |-> !sdoOe_n)
        else $error("Serial output released with tristating off");
    reset_vals_a: assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> mem_r[1][ADDR_ALARM_MASK] == RST_ALARM_MASK &&
        mem_r[0][ADDR_GAIN_LOAD] == RST_GAIN && mem_r[1][ADDR_OFS_LOAD] == RST_OFFSET)
        else $error("Wrong reset value in alarm mask or calibration word");
    resv_read_a: assert property (@(posedge clock) disable iff (srst)
        sclkRise && state_r == ST_SHIFT && bitCnt_r == 5'(HDR_BITS - 1) &&
        {shift_r[5:0], sdiS} == 7'h40 |=> shadow_r == RESERVED_READ)
        else $error("Reserved read returned an unexpected value");

endmodule // dual_channel_spi_register_bank

`default_nettype wire

/* verilog/spi_bank_pkg.sv */
`default_nettype none

package spi_bank_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W = 16;
    localparam int unsigned FRAME_BITS = 26;
    localparam int unsigned HDR_BITS = 10;
    localparam int unsigned POS_RW = 25;
    localparam int unsigned POS_CH_HI = 24;
    localparam int unsigned POS_CH_LO = 23;
    localparam int unsigned POS_ADDR_HI = 22;
    localparam int unsigned POS_ADDR_LO = 16;
    localparam int unsigned HDR_RW = 9;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_LEVEL_FIRST = 7'h01;
    localparam logic [6:0] ADDR_LEVEL_LAST = 7'h0F;
    localparam logic [6:0] ADDR_DAC_CTRL = 7'h11;
    localparam logic [6:0] ADDR_SPI_CTRL = 7'h12;
    localparam logic [6:0] ADDR_DRV_CTRL = 7'h19;
    localparam logic [6:0] ADDR_CMP_CTRL = 7'h1A;
    localparam logic [6:0] ADDR_LOAD_CTRL = 7'h1B;
    localparam logic [6:0] ADDR_PMU_CTRL = 7'h1C;
    localparam logic [6:0] ADDR_ALARM_MASK = 7'h1D;
    localparam logic [6:0] ADDR_ALARM_STATE = 7'h1E;
    localparam logic [6:0] ADDR_SERIAL_CODE = 7'h1F;
    localparam logic [6:0] ADDR_OFS_FIRST = 7'h34;
    localparam logic [6:0] ADDR_OFS_LAST = 7'h3F;
    localparam logic [6:0] ADDR_GAIN_LOAD = 7'h42;
    localparam logic [6:0] ADDR_GAIN_FI_FIRST = 7'h4A;
    localparam logic [6:0] ADDR_GAIN_FI_LAST = 7'h4E;
    localparam logic [6:0] ADDR_OFS_LOAD = 7'h52;
    localparam logic [6:0] ADDR_OFS_FI = 7'h5A;
    localparam logic [6:0] ADDR_GAIN_MI_FIRST = 7'h61;
    localparam logic [6:0] ADDR_GAIN_MI_LAST = 7'h6A;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_LEVEL = 16'h0000;
    localparam logic [15:0] RST_ALARM_MASK = 16'h0085;
    localparam logic [15:0] RST_GAIN = 16'hFFFF;
    localparam logic [15:0] RST_OFFSET = 16'h8000;
    localparam logic [15:0] RESERVED_READ = 16'h0000;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int unsigned BIT_DAC_CAL_EN = 0;
    localparam int unsigned BIT_DAC_DEFER = 1;
    localparam int unsigned BIT_SPI_TRISTATE = 0;
    localparam int unsigned BIT_DRV_EN = 0;
    localparam int unsigned BIT_DRV_ALT_MUX = 1;
    localparam int unsigned BIT_DRV_CLC = 2;
    localparam int unsigned BIT_DRV_RCV_TERM = 3;
    localparam int unsigned BIT_CMP_DIFF = 0;
    localparam int unsigned BIT_CMP_CLC = 1;
    localparam int unsigned BIT_CMP_HYST = 2;
    localparam int unsigned BIT_LOAD_EN = 0;
    localparam int unsigned BIT_PMU_EN = 0;
    localparam int unsigned BIT_PMU_OUT_EN = 1;
    localparam int unsigned BIT_PMU_CLAMP = 2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum {KIND_RESERVED, KIND_CTRL, KIND_LEVEL, KIND_GAIN, KIND_OFFSET,
                  KIND_READ_ONLY} reg_kind_e;

    typedef struct packed {
        logic driverEnable;
        logic driverAltMux;
        logic driverLossComp;
        logic driverRcvTerm;
        logic compDiffMode;
        logic compLossComp;
        logic compHysteresis;
        logic loadEnable;
        logic measureEnable;
        logic measureOutEnable;
        logic measureClamps;
    } chan_ctrl_s;

endpackage

`default_nettype wire

/* verilog/pin_sync.sv */
`default_nettype none

// Two-stage synchroniser for pins from outside the clock domain.
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage1_nxt;
    logic [WIDTH-1:0] stage2_nxt;

    // Next values: the first stage feeds only the second.
    always_comb begin
        stage1_nxt = srst ? '0 : pinIn;
        stage2_nxt = srst ? '0 : stage1_r;
    end

    // Stage registers.
    always_ff @(posedge clock) begin
        stage1_r <= stage1_nxt;
        stage2_r <= stage2_nxt;
    end

    assign pinSync = stage2_r;

endmodule // pin_sync

`default_nettype wire

/* tb/spi_host_model.sv */
`default_nettype none

// Serial host: drives 26-bit mode 0 frames, most significant bit first.
module spi_host_model (
    output logic sclk,
    output logic csN,
    output logic sdi,
    input wire logic sdoOut,
    input wire logic sdoOe_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle: select high, clock parked low.
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end

    // One frame; the reply bits are taken just before rises 11 to 26.
    task automatic frame(input logic rw, input logic [1:0] ch, input logic [6:0] addr,
                         input logic [15:0] data, output logic [15:0] rd);
        logic [25:0] word;
        word = {rw, ch, addr, data};
        rd = 16'h0000;
        csN = 1'b0;
        #62.5;
        for (int i = 25; i >= 0; i--) begin
            sdi = word[i];
            #62.5;
            if (i < 16) rd = {rd[14:0], sdoOe_n ? ~rd[0] : sdoOut};
            sclk = 1'b1;
            #62.5;
            sclk = 1'b0;
        end
        sdi = ~sdi; // Line is flipped, not released, so the last data bit does not linger.
        #62.5;
        csN = 1'b1;
        #250;
    endtask
endmodule // spi_host_model

`default_nettype wire

/* tb/dual_channel_spi_register_bank_tb.sv */
`default_nettype none

module dual_channel_spi_register_bank_tb
    import spi_bank_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] CODE = 16'h1234; // Arbitrary value.
    logic clock, srst, sclk, csN, sdi, sdoOut, sdoOe_n, alarmOut, alarmOe_n;
    logic calEnable, loadDeferred;
    logic [31:0] alarmIn;
    logic [1:0] activeLoadOn;
    chan_ctrl_s [1:0] chanCtrl;
    logic [15:0] v;
    int nFail, samplesChecked;

    dual_channel_spi_register_bank #(.SERIAL_CODE(CODE), .ALARM_W(16)) uut (
        .clock(clock), .srst(srst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut),
        .sdoOe_n(sdoOe_n), .alarmIn(alarmIn), .alarmOut(alarmOut), .alarmOe_n(alarmOe_n),
        .calEnable(calEnable), .loadDeferred(loadDeferred), .activeLoadOn(activeLoadOn),
        .chanCtrl(chanCtrl));
    spi_host_model host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut),
        .sdoOe_n(sdoOe_n));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            nFail++;
        end
    endtask
    task automatic rd(input logic [1:0] ch, input logic [6:0] a);
        host.frame(1'b1, ch, a, 16'h0000, v);
    endtask
    task automatic wr(input logic [1:0] ch, input logic [6:0] a, input logic [15:0] d);
        logic [15:0] dummy;
        host.frame(1'b0, ch, a, d, dummy);
    endtask
    task automatic complete_run();
        if (nFail == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        rd(2'b01, ADDR_ALARM_MASK); check("alarm_mask", RST_ALARM_MASK, v);
        rd(2'b01, ADDR_GAIN_LOAD); check("gain", RST_GAIN, v);
        rd(2'b01, ADDR_OFS_LOAD); check("offset", RST_OFFSET, v);
        rd(2'b01, ADDR_SERIAL_CODE); check("serial_code", CODE, v);
        check("active_load", 16'h0003, {14'h0, activeLoadOn});
        check("chan_ctrl", 16'h0000, {5'h0, chanCtrl[0] | chanCtrl[1]});
        check("dac_pins", 16'h0000, {14'h0, calEnable, loadDeferred});
        check("sdo_enable", 16'h0000, {15'h0, sdoOe_n});
    endtask
    task automatic test_reserved();
        wr(2'b11, 7'h43, 16'h1234);
        wr(2'b11, 7'h19 + 7'h27, 16'hFFFF);
        rd(2'b01, 7'h40); check("reserved_a", RESERVED_READ, v);
        rd(2'b01, 7'h40); check("reserved_b", RESERVED_READ, v);
        rd(2'b01, ADDR_GAIN_LOAD); check("gain_kept", RST_GAIN, v);
        check("ctrl_kept", 16'h0000, {5'h0, chanCtrl[0] | chanCtrl[1]});
    endtask
    task automatic test_channels();
        wr(2'b01, ADDR_DRV_CTRL, 16'h000F);
        check("drv_ch0", 16'h0780, {5'h0, chanCtrl[0]});
        check("drv_ch1", 16'h0000, {5'h0, chanCtrl[1]});
        wr(2'b10, ADDR_DAC_CTRL, 16'h0003);
        check("dac_ch1_only", 16'h0000, {14'h0, calEnable, loadDeferred});
        wr(2'b11, ADDR_DAC_CTRL, 16'h0003);
        check("dac_both", 16'h0003, {14'h0, calEnable, loadDeferred});
        wr(2'b11, ADDR_CMP_CTRL, 16'h0007);
        check("cmp_ch0", 16'h07F0, {5'h0, chanCtrl[0]});
        check("cmp_ch1", 16'h0070, {5'h0, chanCtrl[1]});
    endtask
    task automatic test_read_only();
        @(posedge clock); #1 alarmIn = 32'h0000_0002;
        repeat (10) @(posedge clock);
        check("alarm_low", 16'h0000, {15'h0, alarmOe_n});
        check("alarm_data", 16'h0000, {15'h0, alarmOut});
        wr(2'b01, ADDR_ALARM_STATE, 16'hFFFF);
        rd(2'b01, ADDR_ALARM_STATE); check("alarm_state", 16'h0002, v);
        @(posedge clock); #1 alarmIn = 32'h0000_0001;
        repeat (10) @(posedge clock);
        check("alarm_masked", 16'h0001, {15'h0, alarmOe_n});
        wr(2'b11, ADDR_SERIAL_CODE, 16'h0000);
        rd(2'b01, ADDR_SERIAL_CODE); check("code_kept", CODE, v);
    endtask
    task automatic test_tristate();
        wr(2'b01, ADDR_SPI_CTRL, 16'h0001);
        check("sdo_released", 16'h0001, {15'h0, sdoOe_n});
        wr(2'b01, ADDR_SPI_CTRL, 16'h0000);
        check("sdo_driven", 16'h0000, {15'h0, sdoOe_n});
    endtask
    task automatic test_midreset();
        wr(2'b11, ADDR_ALARM_MASK, 16'h0000);
        wr(2'b01, ADDR_GAIN_LOAD, 16'h1234);
        rd(2'b10, ADDR_ALARM_MASK); check("mask_ch1_set", 16'h0000, v);
        @(posedge clock);
        #1 srst = 1'b1;
        repeat (2) @(posedge clock);
        #1 srst = 1'b0;
        repeat (5) @(posedge clock);
        check("load_after_reset", 16'h0003, {14'h0, activeLoadOn});
        rd(2'b10, ADDR_ALARM_MASK); check("mask_ch1_reset", RST_ALARM_MASK, v);
        rd(2'b01, ADDR_GAIN_LOAD); check("gain_reset", RST_GAIN, v);
    endtask

    // Clock, reset and the main sequence.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        srst = 1'b1;
        alarmIn = 32'h0;
        nFail = 0;
        samplesChecked = 0;
        repeat (6) @(posedge clock);
        #1 srst = 1'b0;
        repeat (5) @(posedge clock);
        test_reset();
        test_reserved();
        test_channels();
        test_read_only();
        test_tristate();
        test_midreset();
        complete_run();
    end
    // Watchdog against a hung frame.
    initial begin
        #500000;
        nFail++;
        complete_run();
    end
endmodule // dual_channel_spi_register_bank_tb

`default_nettype wire
